// >>> adc_ctrl.sv
// Converter control: APB register file, trigger and sequencing of one 12-bit
// conversion, result formatting and analog routing controls.
// Assumes the analog core presents a settled result on conv_result_i by the
// last converter clock period, and the pin-share logic reports analog pins.
// Functional notes
// - Alignment 0 gives high=11..4, low=3..0 upper; alignment 1 gives low=7..0, high=11..8.
// - A conversion starts when start is written high then low again.
// - Busy flag is read only, set on trigger, cleared at completion.
// - Enable low powers core down and result registers keep contents.
// - Channel codes 0, 1, 6, 7 pick inputs 0, 1, 6, 7; others reserved.
// - Source field routes external, supply fractions, amplified reference fractions or ground.
// - Internal source selected disconnects the external channel regardless of channel field.
// - Converter clock is system clock divided by two to the code.
// - Unimplemented control bits read as zero.
// - Amplifier enable bit turns the reference gain amplifier on or off.
// - Amplifier input takes pin at 0, bandgap at 1; bandgap disconnects pin.
// - Reference select picks supply, external pin or amplifier; internal disconnects pin.
// - Gain field drives amplifier gain selection 1, 1.667, 2.5, 3.333.
// - Pins used as converter inputs lose digital function and pull-high.
// - Conversion takes four sampling plus twelve converting converter clock periods.
// - Completion raises the interrupt request together with busy falling.
// - Result bit positions without a result bit read as zero.
`timescale 1ns/1ps
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int RES_BITS  = 12,
    parameter int NUM_PINS  = 4
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                srst_i,
    // APB slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // Analog core
    input  wire logic [RES_BITS-1:0] conv_result_i,
    output logic                     conv_clk_tick_o,
    output logic                     sampling_o,
    output logic                     busy_o,
    output logic                     irq_req_o,
    output adc_route_t               route_o,
    // Pin sharing
    input  wire logic [NUM_PINS-1:0] pin_analog_mode_i,
    output logic      [NUM_PINS-1:0] pin_digital_off_o,
    output logic      [NUM_PINS-1:0] pin_pullup_off_o
);

    // ==========================================================
    // Parameter checks
    if (RES_BITS != 12) begin : g_bad_res
        $error("adc_ctrl supports a 12-bit result only");
    end
    if (NUM_PINS < 1) begin : g_bad_pins
        $error("adc_ctrl needs at least one shared pin");
    end

    // ==========================================================
    // Register state
    logic                start_bit, next_start_bit;
    logic                enable, next_enable;
    logic                align, next_align;
    logic [3:0]          ch_sel, next_ch_sel;
    logic [3:0]          src_sel, next_src_sel;
    logic [2:0]          clk_div, next_clk_div;
    logic                amp_en, next_amp_en;
    logic                amp_in, next_amp_in;
    logic [1:0]          ref_sel, next_ref_sel;
    logic [1:0]          gain_sel, next_gain_sel;
    logic                bg_en, next_bg_en;

    // Bus decode
    logic                wr_en;
    logic                rd_en;
    logic                mapped;
    logic                trigger;

    always_comb begin
        wr_en   = psel_i & penable_i & pwrite_i;
        rd_en   = psel_i & penable_i & ~pwrite_i;
        mapped  = (paddr_i == ADDR_RESULT_LOW) | (paddr_i == ADDR_RESULT_HIGH)
                | (paddr_i == ADDR_MAIN_CTRL) | (paddr_i == ADDR_SOURCE_CLOCK)
                | (paddr_i == ADDR_REF_GAIN) | (paddr_i == ADDR_BANDGAP);
        // Falling write of a previously set start bit, enabled and idle
        trigger = wr_en & (paddr_i == ADDR_MAIN_CTRL) & start_bit
                & ~pwdata_i[MC_START_BIT] & pwdata_i[MC_ENABLE_BIT] & ~busy_o;
    end

    // Register writes; busy bit and result registers are not writable
    always_comb begin
        next_start_bit = start_bit;
        next_enable    = enable;
        next_align     = align;
        next_ch_sel    = ch_sel;
        next_src_sel   = src_sel;
        next_clk_div   = clk_div;
        next_amp_en    = amp_en;
        next_amp_in    = amp_in;
        next_ref_sel   = ref_sel;
        next_gain_sel  = gain_sel;
        next_bg_en     = bg_en;
        if (wr_en) begin
            case (paddr_i)
                ADDR_MAIN_CTRL: begin
                    next_start_bit = pwdata_i[MC_START_BIT];
                    next_enable    = pwdata_i[MC_ENABLE_BIT];
                    next_align     = pwdata_i[MC_ALIGN_BIT];
                    next_ch_sel    = pwdata_i[3:0];
                end
                ADDR_SOURCE_CLOCK: begin
                    next_src_sel = pwdata_i[SC_SRC_LSB +: 4];
                    next_clk_div = pwdata_i[2:0];
                end
                ADDR_REF_GAIN: begin
                    next_amp_en   = pwdata_i[RG_AMP_EN_BIT];
                    next_amp_in   = pwdata_i[RG_AMP_IN_BIT];
                    next_ref_sel  = pwdata_i[RG_REF_LSB +: 2];
                    next_gain_sel = pwdata_i[1:0];
                end
                ADDR_BANDGAP: begin
                    next_bg_en = pwdata_i[BG_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            start_bit <= RST_MAIN_CTRL[MC_START_BIT];
            enable    <= RST_MAIN_CTRL[MC_ENABLE_BIT];
            align     <= RST_MAIN_CTRL[MC_ALIGN_BIT];
            ch_sel    <= RST_MAIN_CTRL[3:0];
            src_sel   <= RST_SOURCE_CLOCK[SC_SRC_LSB +: 4];
            clk_div   <= RST_SOURCE_CLOCK[2:0];
            amp_en    <= RST_REF_GAIN[RG_AMP_EN_BIT];
            amp_in    <= RST_REF_GAIN[RG_AMP_IN_BIT];
            ref_sel   <= RST_REF_GAIN[RG_REF_LSB +: 2];
            gain_sel  <= RST_REF_GAIN[1:0];
            bg_en     <= RST_BANDGAP[BG_ENABLE_BIT];
        end else begin
            start_bit <= next_start_bit;
            enable    <= next_enable;
            align     <= next_align;
            ch_sel    <= next_ch_sel;
            src_sel   <= next_src_sel;
            clk_div   <= next_clk_div;
            amp_en    <= next_amp_en;
            amp_in    <= next_amp_in;
            ref_sel   <= next_ref_sel;
            gain_sel  <= next_gain_sel;
            bg_en     <= next_bg_en;
        end
    end

    // ==========================================================
    // Conversion sequencer
    adc_state_t          state, next_state;
    logic [2:0]          conv_div, next_conv_div;
    logic [6:0]          div_cnt, next_div_cnt;
    logic [3:0]          per_cnt, next_per_cnt;
    logic [11:0]         result, next_result;
    logic                done_q, next_done_q;
    logic [6:0]          div_mask;
    logic                tick;

    // Divider is latched at trigger so a mid-conversion write cannot stretch it
    always_comb begin
        div_mask      = 7'((8'h01 << conv_div) - 8'h01);
        tick          = (div_cnt == div_mask);
        next_state    = state;
        next_conv_div = conv_div;
        next_div_cnt  = div_cnt;
        next_per_cnt  = per_cnt;
        next_result   = result;
        next_done_q   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (trigger) begin
                    next_state    = ST_SAMPLE;
                    next_conv_div = clk_div;
                    next_div_cnt  = 7'h00;
                    next_per_cnt  = 4'h0;
                end
            end
            ST_SAMPLE, ST_CONVERT: begin
                if (!enable) begin
                    next_state = ST_IDLE;
                end else begin
                    next_div_cnt = tick ? 7'h00 : 7'(div_cnt + 7'h01);
                    if (tick) begin
                        next_per_cnt = 4'(per_cnt + 4'h1);
                        if (per_cnt == 4'(SAMPLE_PERIODS - 1)) begin
                            next_state = ST_CONVERT;
                        end
                        if (per_cnt == 4'(TOTAL_PERIODS - 1)) begin
                            next_state  = ST_IDLE;
                            next_result = conv_result_i;
                            next_done_q = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state    <= ST_IDLE;
            conv_div <= 3'h0;
            div_cnt  <= 7'h00;
            per_cnt  <= 4'h0;
            result   <= 12'h000;
            done_q   <= 1'b0;
        end else begin
            state    <= next_state;
            conv_div <= next_conv_div;
            div_cnt  <= next_div_cnt;
            per_cnt  <= next_per_cnt;
            result   <= next_result;
            done_q   <= next_done_q;
        end
    end

    // Busy falls at the same edge that raises the request
    always_comb begin
        busy_o          = (state != ST_IDLE);
        irq_req_o       = done_q;
        sampling_o      = (state == ST_SAMPLE);
        conv_clk_tick_o = busy_o & tick;
    end

    // ==========================================================
    // Analog routing and pin controls, registered
    adc_route_t          next_route;
    logic [NUM_PINS-1:0] next_pin_off;
    logic [NUM_PINS-1:0] pin_off;

    always_comb begin
        next_route                = '0;
        next_route.core_power     = enable;
        next_route.bandgap_enable = bg_en;
        // Source decode: 0000, 0100, 11xx external; 10xx ground
        if (src_sel[3:2] == 2'b11 || src_sel[1:0] == 2'b00 && !src_sel[3]) begin
            next_route.internal_src = SRC_NONE;
        end else if (src_sel[3]) begin
            next_route.internal_src = SRC_GROUND;
        end else begin
            // 0001..0011 give 1..3, 0101..0111 give 4..6
            next_route.internal_src = src_sel[2:0] - {2'b00, src_sel[2]};
        end
        next_route.int_src_active = (next_route.internal_src != SRC_NONE);
        // Reserved channel codes connect nothing
        if (!next_route.int_src_active) begin
            case (ch_sel)
                4'h0:    next_route.ext_ch_connect = 4'h1;
                4'h1:    next_route.ext_ch_connect = 4'h2;
                4'h6:    next_route.ext_ch_connect = 4'h4;
                4'h7:    next_route.ext_ch_connect = 4'h8;
                default: next_route.ext_ch_connect = 4'h0;
            endcase
        end
        next_route.ref_sel            = ref_sel[1] ? 2'h2 : ref_sel;
        next_route.ext_ref_connect    = (ref_sel == 2'b01);
        next_route.amp_enable         = amp_en;
        next_route.amp_bandgap_in     = amp_in;
        next_route.amp_ext_in_connect = ~amp_in;
        next_route.gain_sel           = gain_sel;
        next_pin_off                  = pin_analog_mode_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            route_o <= '0;
            pin_off <= '0;
        end else begin
            route_o <= next_route;
            pin_off <= next_pin_off;
        end
    end

    always_comb begin
        pin_digital_off_o = pin_off;
        pin_pullup_off_o  = pin_off;
    end

    // ==========================================================
    // APB read mux and answer; zero wait states
    logic [7:0] rd_byte;

    always_comb begin
        case (paddr_i)
            ADDR_RESULT_LOW:   rd_byte = align ? result[7:0] : {result[3:0], 4'h0};
            ADDR_RESULT_HIGH:  rd_byte = align ? {4'h0, result[11:8]} : result[11:4];
            ADDR_MAIN_CTRL:    rd_byte = {start_bit, busy_o, enable, align, ch_sel};
            ADDR_SOURCE_CLOCK: rd_byte = {src_sel, 1'b0, clk_div};
            ADDR_REF_GAIN:     rd_byte = {amp_en, 2'b00, amp_in, ref_sel, gain_sel};
            ADDR_BANDGAP:      rd_byte = {7'h00, bg_en};
            default:           rd_byte = 8'h00;
        endcase
        prdata_o  = rd_en ? {24'h000000, rd_byte} : 32'h00000000;
        pready_o  = 1'b1;
        pslverr_o = psel_i & penable_i & ~mapped;
    end

    // ==========================================================
    // Assertions
    logic [11:0] busy_len;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            busy_len <= 12'h000;
        end else if (trigger) begin
            busy_len <= 12'h000;
        end else if (busy_o) begin
            busy_len <= 12'(busy_len + 12'h001);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_busy_set: assert property (trigger |=> busy_o && sampling_o)
        else $error("busy not set after trigger");
    a_conv_time: assert property (irq_req_o |-> busy_len == 12'(TOTAL_PERIODS << conv_div))
        else $error("conversion length wrong");
    a_irq_busy: assert property (irq_req_o |-> !busy_o && $past(busy_o))
        else $error("request not aligned with busy fall");
    a_hold_disabled: assert property (!enable |=> $stable(result))
        else $error("result changed while disabled");
    a_result_pair: assert property ($changed(result) |-> irq_req_o)
        else $error("result changed outside completion");
    a_align_zero: assert property (rd_en && paddr_i == ADDR_RESULT_LOW && !align |-> prdata_o[3:0] == 4'h0)
        else $error("unused result bits not zero");
    a_ext_off: assert property (route_o.int_src_active |-> route_o.ext_ch_connect == 4'h0)
        else $error("external channel joined to internal source");
    a_ref_pin_off: assert property (route_o.ref_sel != 2'h1 |-> !route_o.ext_ref_connect)
        else $error("external reference pin left connected");
    a_unused_zero: assert property (rd_en && paddr_i == ADDR_SOURCE_CLOCK |-> prdata_o[3] == 1'b0)
        else $error("unimplemented bit reads one");

    c_full_conv: cover property (trigger ##[16:64] irq_req_o);
    c_abort: cover property (busy_o ##1 !enable ##1 !busy_o);
    c_slow_div: cover property (trigger && clk_div == 3'h7);

endmodule : adc_ctrl

// >>> adc_pkg.sv
// Package for the converter control block: register offsets, field positions,
// reset values, timing counts, state and carrier types.
// Assumes a 32-bit APB bus with byte addresses, one aligned word per register.
package adc_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_RESULT_LOW    = 8'h00;
    localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h04;
    localparam logic [7:0] ADDR_MAIN_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_SOURCE_CLOCK  = 8'h0C;
    localparam logic [7:0] ADDR_REF_GAIN      = 8'h10;
    localparam logic [7:0] ADDR_BANDGAP       = 8'h14;

    // ==========================================================
    // Field positions
    localparam int MC_START_BIT  = 7;
    localparam int MC_BUSY_BIT   = 6;
    localparam int MC_ENABLE_BIT = 5;
    localparam int MC_ALIGN_BIT  = 4;
    localparam int SC_SRC_LSB    = 4;
    localparam int RG_AMP_EN_BIT = 7;
    localparam int RG_AMP_IN_BIT = 4;
    localparam int RG_REF_LSB    = 2;
    localparam int BG_ENABLE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MAIN_CTRL    = 8'h00;
    localparam logic [7:0] RST_SOURCE_CLOCK = 8'h00;
    localparam logic [7:0] RST_REF_GAIN     = 8'h00;
    localparam logic [7:0] RST_BANDGAP      = 8'h00;

    // ==========================================================
    // Conversion timing in converter clock periods
    localparam int SAMPLE_PERIODS  = 4;
    localparam int CONVERT_PERIODS = 12;
    localparam int TOTAL_PERIODS   = SAMPLE_PERIODS + CONVERT_PERIODS;

    // ==========================================================
    // Internal source codes on the routing carrier
    localparam logic [2:0] SRC_NONE     = 3'h0;
    localparam logic [2:0] SRC_SUPPLY   = 3'h1;
    localparam logic [2:0] SRC_GROUND   = 3'h7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adc_state_t;

    typedef struct packed {
        logic [3:0] ext_ch_connect;     // One-hot: input 0, 1, 6, 7
        logic [2:0] internal_src;       // 1..3 supply, 4..6 amp ref, 7 ground
        logic       int_src_active;
        logic [1:0] ref_sel;            // 0 supply, 1 ext pin, 2 amplifier
        logic       ext_ref_connect;
        logic       amp_enable;
        logic       amp_bandgap_in;
        logic       amp_ext_in_connect;
        logic [1:0] gain_sel;
        logic       bandgap_enable;
        logic       core_power;
    } adc_route_t;

endpackage : adc_pkg

// >>> adc_core_model.sv
// Behavioural analog core that sits behind the converter control block.
// Assumes the control block keeps busy high until it has latched the result.
`timescale 1ns/1ps
module adc_core_model (
    // Conversion status from the control block
    input  wire logic        busy_i,
    // Analog level chosen by the bench
    input  wire logic [11:0] level_i,
    // Raw result towards the control block
    output logic      [11:0] result_o
);
    // ==========================================================
    // Result path
    // Outside a conversion the core holds nothing settled, so the inverse is
    // shown; a block that latches at the wrong moment then reads a wrong value
    always_comb begin
        result_o = busy_i ? level_i : ~level_i;
    end
endmodule : adc_core_model

// >>> adc_control_registers_tb.sv
// Self-checking bench for the converter control block.
// Assumes a 200 MHz clock, the APB master below and a behavioural analog core.
`timescale 1ns/1ps
module adc_control_registers_tb;
    import adc_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_i, srst_i, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] level, conv_res;
    logic        tick, samp, busy, irq;
    adc_route_t  route;
    logic [3:0]  pin_mode, dig_off, pull_off;
    int          fail_count, compares;

    adc_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .conv_result_i(conv_res), .conv_clk_tick_o(tick), .sampling_o(samp), .busy_o(busy),
        .irq_req_o(irq), .route_o(route), .pin_analog_mode_i(pin_mode), .pin_digital_off_o(dig_off),
        .pin_pullup_off_o(pull_off));
    adc_core_model core (.busy_i(busy), .level_i(level), .result_o(conv_res));

    // Free-running 5 ns clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        compares++;
        if (seen !== expd) begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expd);
        end
    endtask : check

    task automatic results();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // One APB transfer; read data and error are taken at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        @(posedge clk_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge clk_i);
            rdy = pready;
            rd  = prdata;
            err = pslverr;
            if (rdy === 1'b1) break;
        end
        if (rdy !== 1'b1) begin
            fail_count++;
            results();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] expd);
        apb(1'b0, a, 32'h0);
        check(rd, expd);
    endtask : rdchk

    // Routing outputs follow their register one cycle late
    task automatic settle();
        repeat (2) @(negedge clk_i);
    endtask : settle

    function automatic logic [2:0] exp_src(input logic [3:0] c);
        case (c)
            4'h1, 4'h2, 4'h3: return c[2:0];
            4'h5, 4'h6, 4'h7: return c[2:0] - 3'h1;
            4'h8, 4'h9, 4'hA, 4'hB: return SRC_GROUND;
            default: return SRC_NONE;
        endcase
    endfunction : exp_src

    function automatic logic [3:0] exp_ch(input logic [3:0] c);
        case (c)
            4'h0: return 4'h1;
            4'h1: return 4'h2;
            4'h6: return 4'h4;
            4'h7: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction : exp_ch

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        for (int i = 0; i < 6; i++) begin
            rdchk(8'(i * 4), 32'h0);
        end
        apb(1'b1, 8'h18, 32'hFF);
        check(err, 1'b1);
        rdchk(8'h18, 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_fields();
        logic [3:0] v;
        apb(1'b1, ADDR_SOURCE_CLOCK, 32'hFF);
        rdchk(ADDR_SOURCE_CLOCK, 32'hF7);
        // Bandgap is enabled before any code below selects it as amplifier input
        apb(1'b1, ADDR_BANDGAP, 32'hFF);
        rdchk(ADDR_BANDGAP, 32'h01);
        settle();
        check(route.bandgap_enable, 1'b1);
        // Walk every reference and gain code with both amplifier bits
        for (int c = 0; c < 16; c++) begin
            v = c[3:0];
            apb(1'b1, ADDR_REF_GAIN, {24'h0, v[0], 2'b11, v[1], v[3:2], v[1:0]});
            rdchk(ADDR_REF_GAIN, {24'h0, v[0], 2'b00, v[1], v[3:2], v[1:0]});
            settle();
            check(route.amp_enable, v[0]);
            check({route.amp_bandgap_in, route.amp_ext_in_connect}, {v[1], ~v[1]});
            check(route.ref_sel, v[3] ? 2'h2 : v[3:2]);
            check(route.ext_ref_connect, v[3:2] == 2'h1);
            check(route.gain_sel, v[1:0]);
        end
        apb(1'b1, ADDR_MAIN_CTRL, 32'h07);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ADDR_SOURCE_CLOCK, {24'h0, c[3:0], 4'h0});
            settle();
            check(route.internal_src, exp_src(c[3:0]));
            check(route.ext_ch_connect, exp_src(c[3:0]) != 3'h0 ? 4'h0 : 4'h8);
        end
        apb(1'b1, ADDR_SOURCE_CLOCK, 32'h0);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ADDR_MAIN_CTRL, {24'h0, 4'h2, c[3:0]});
            settle();
            check(route.ext_ch_connect, exp_ch(c[3:0]));
        end
        $display("test_fields done");
    endtask : test_fields

    task automatic test_convert(input logic [2:0] div, input logic al, input logic [11:0] lvl,
                                input logic [7:0] lo, input logic [7:0] hi);
        int   nb, ns, nt;
        logic done;
        nb = 0;
        ns = 0;
        nt = 0;
        done = 1'b0;
        level <= lvl;
        apb(1'b1, ADDR_SOURCE_CLOCK, {29'h0, div});
        apb(1'b1, ADDR_MAIN_CTRL, {24'h0, 3'b111, al, 4'h0});
        rdchk(ADDR_MAIN_CTRL, {24'h0, 3'b101, al, 4'h0});
        check(busy, 1'b0);
        apb(1'b1, ADDR_MAIN_CTRL, {24'h0, 3'b001, al, 4'h0});
        // Count busy, sampling and converter ticks until completion
        for (int n = 0; n < 3000; n++) begin
            @(negedge clk_i);
            if (busy === 1'b0 && nb > 0) begin
                check(irq, 1'b1);
                done = 1'b1;
                break;
            end
            nb += int'(busy);
            ns += int'(samp);
            nt += int'(tick);
        end
        if (!done) begin
            fail_count++;
            results();
        end
        check(nb, TOTAL_PERIODS << div);
        check(ns, SAMPLE_PERIODS << div);
        check(nt, TOTAL_PERIODS);
        rdchk(ADDR_RESULT_LOW, lo);
        rdchk(ADDR_RESULT_HIGH, hi);
        apb(1'b1, ADDR_RESULT_LOW, 32'hFF);
        rdchk(ADDR_RESULT_LOW, lo);
        $display("test_convert done");
    endtask : test_convert

    task automatic test_abort();
        logic seen;
        seen = 1'b0;
        level <= 12'h0F0;
        apb(1'b1, ADDR_SOURCE_CLOCK, 32'h07);
        apb(1'b1, ADDR_MAIN_CTRL, 32'hA0);
        apb(1'b1, ADDR_MAIN_CTRL, 32'h20);
        apb(1'b1, ADDR_MAIN_CTRL, 32'h00);
        // Enable falls at the write edge; busy and power follow one edge later
        repeat (2) @(negedge clk_i);
        check(busy, 1'b0);
        check(route.core_power, 1'b0);
        // With the slow divider a full conversion would need 2048 cycles, far beyond this span
        repeat (200) begin
            @(negedge clk_i);
            seen = seen | irq;
        end
        check(seen, 1'b0);
        rdchk(ADDR_RESULT_LOW, 32'h70);
        rdchk(ADDR_RESULT_HIGH, 32'h3E);
        $display("test_abort done");
    endtask : test_abort

    task automatic test_pins();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            pin_mode <= i ? 4'h5 : 4'hA;
            settle();
            check({dig_off, pull_off}, i ? 8'h55 : 8'hAA);
        end
        $display("test_pins done");
    endtask : test_pins

    // ==========================================================
    // Main sequence
    initial begin
        fail_count = 0;
        compares = 0;
        srst_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        level = 12'h000;
        pin_mode = 4'h0;
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        test_reset();
        test_fields();
        test_convert(3'h0, 1'b0, 12'hA5C, 8'hC0, 8'hA5);
        test_convert(3'h3, 1'b1, 12'h3E7, 8'hE7, 8'h03);
        test_abort();
        test_pins();
        results();
    end
endmodule : adc_control_registers_tb
